/* hdl/plw_pkg.sv */
package plw_pkg;
   // ****************************************
   // register map (indices, byte address = 4 x index)
   // ****************************************
   localparam logic [7:0] FINE_IDX = 8'h73;
   localparam logic [7:0] COARSE_IDX = 8'h74;
   localparam logic [7:0] STATUS_IDX = 8'h75;
   localparam logic [7:0] IRQ_STAT_IDX = 8'h76;
   localparam logic [7:0] IRQ_MASK_IDX = 8'h77;
   localparam logic [7:0] FINE_RST = 8'hA2;
   localparam logic [7:0] COARSE_RST = 8'h85;
   localparam logic [1:0] MASK_RST = 2'h0;
   // ****************************************
   // field positions
   // ****************************************
   localparam int FINE_EN_BIT = 7;
   localparam int NOACT_BIT = 6;
   localparam int NARROW_BIT = 5;
   localparam int COARSE_EN_BIT = 7;
   localparam int WIDE_BIT = 6;
   localparam int MULTI_BIT = 5;
   localparam int IRQ_LOST_BIT = 0;
   localparam int IRQ_LOCK_BIT = 1;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int LOCK_TIME_S = 1;
   localparam int LOCK_CYCLES = LOCK_TIME_S * CLK_HZ;
   localparam int WIN_UNIT_DEG = 45;
   typedef enum logic [1:0] {
      PLW_LOST = 2'b00,
      PLW_QUAL = 2'b01,
      PLW_LOCK = 2'b11
   } plw_state_t;
   // first field is the top bit: the layout matches the register byte
   typedef struct packed {
      logic fine_en;
      logic inactivity_loss_select;
      logic narrow;
      logic [1:0] spare;
      logic [2:0] win_code;
   } plw_fine_t;
   typedef struct packed {
      logic coarse_en;
      logic wide_en;
      logic multi_cycle_response;
      logic spare;
      logic [3:0] limit_ui;
   } plw_coarse_t;
endpackage : plw_pkg

/* hdl/plw_phase_loss.sv */
`timescale 1ns/1ps
module plw_phase_loss #(
   parameter int LOCK_CNT = plw_pkg::LOCK_CYCLES
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // phase detector measurements
   input wire logic [15:0] PHASE_ERR_DEG,
   input wire logic [7:0] PHASE_ERR_UI,
   input wire logic NO_ACTIVITY,
   input wire logic OTHER_LOSS,
   // indications
   output logic PHASE_LOST,
   output logic PHASE_LOCKED,
   output logic IRQ
);
   // ****************************************
   // register file and internal state
   // ****************************************
   // software visible configuration, reset to the power-up defaults
   plw_pkg::plw_fine_t fine_q;
   plw_pkg::plw_coarse_t coarse_q;
   // sticky event flags and their enables
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   // lock qualification state and dwell count
   plw_pkg::plw_state_t state_q;
   logic [31:0] dwell_q;

   // bus decode terms
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [7:0] idx;
   logic sel_fine;
   logic sel_coarse;
   logic sel_status;
   logic sel_irq_stat;
   logic sel_irq_mask;
   logic [31:0] rdata_d;

   // loss causes, each already gated by its own enable
   logic fine_out;
   logic coarse_out;
   logic inact_out;
   logic lose_now;
   logic [15:0] win_deg;
   logic [7:0] limit_ext;

   // qualification helpers
   logic dwell_done;
   logic [31:0] dwell_last;

   // interrupt events, one bit per status flag
   logic lost_evt;
   logic lock_evt;
   logic [1:0] evt_vec;
   logic [1:0] clr_vec;

   // ****************************************
   // bus decode
   // ****************************************
   // only a small block of words is mapped; the decode is kept exact so that
   // a stray access to a neighbouring word never disturbs the configuration
   // word index from the byte address; one register per aligned word
   assign idx = PADDR[9:2];

   // one select per register, so each register write below reads a single term
   assign sel_fine = (idx == plw_pkg::FINE_IDX);
   assign sel_coarse = (idx == plw_pkg::COARSE_IDX);
   assign sel_status = (idx == plw_pkg::STATUS_IDX);
   assign sel_irq_stat = (idx == plw_pkg::IRQ_STAT_IDX);
   assign sel_irq_mask = (idx == plw_pkg::IRQ_MASK_IDX);

   // upper address bits and byte lanes must be clear, else the access is refused
   assign hit = (PADDR[31:10] == 22'h0) && (PADDR[1:0] == 2'h0) &&
      (sel_fine || sel_coarse || sel_status || sel_irq_stat || sel_irq_mask);

   // writes take effect in the access phase only
   assign wr_en = PSEL && PENABLE && PWRITE && hit;
   // reads are captured in setup so the data stands for the whole access phase
   assign rd_en = PSEL && !PENABLE && !PWRITE;

   // zero wait states; unmapped access answers with an error
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;

   // ****************************************
   // configuration registers
   // ****************************************
   // fine window control; bits 4:3 have no function but read back as written
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         fine_q <= plw_pkg::plw_fine_t'(plw_pkg::FINE_RST);
      end else if (wr_en && sel_fine) begin
         fine_q <= plw_pkg::plw_fine_t'(PWDATA[7:0]);
      end
   end

   // coarse limit control; range and response bits are stored but unused here
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         coarse_q <= plw_pkg::plw_coarse_t'(plw_pkg::COARSE_RST);
      end else if (wr_en && sel_coarse) begin
         coarse_q <= plw_pkg::plw_coarse_t'(PWDATA[7:0]);
      end
   end

   // interrupt enables, cleared at reset so nothing fires before software asks
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         irq_mask_q <= plw_pkg::MASK_RST;
      end else if (wr_en && sel_irq_mask) begin
         irq_mask_q <= PWDATA[1:0];
      end
   end

   // ****************************************
   // read path
   // ****************************************
   // status reads the registered flags, so a read never sees a half-way state
   // read mux; unmapped words read as zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (idx)
         plw_pkg::FINE_IDX: begin
            rdata_d = {24'h00_0000, 8'(fine_q)};
         end
         plw_pkg::COARSE_IDX: begin
            rdata_d = {24'h00_0000, 8'(coarse_q)};
         end
         plw_pkg::STATUS_IDX: begin
            rdata_d = {30'h0000_0000, PHASE_LOCKED, PHASE_LOST};
         end
         plw_pkg::IRQ_STAT_IDX: begin
            rdata_d = {30'h0000_0000, irq_stat_q};
         end
         plw_pkg::IRQ_MASK_IDX: begin
            rdata_d = {30'h0000_0000, irq_mask_q};
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // read data registered in setup so it is stable during access
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
      end else if (rd_en) begin
         PRDATA <= hit ? rdata_d : 32'h0000_0000;
      end
   end

   // ****************************************
   // phase decisions
   // ****************************************
   // window grows in proportion to the code, 45 degrees per step; code 0 gives
   // no window at all, which is why software must never program it
   assign win_deg = 16'(fine_q.win_code * plw_pkg::WIN_UNIT_DEG);

   // fine check only counts while its enable is set; strictly greater trips
   assign fine_out = fine_q.fine_en && (PHASE_ERR_DEG > win_deg);

   // limit is compared against the error expressed in input cycles
   assign limit_ext = {4'h0, coarse_q.limit_ui};
   assign coarse_out = coarse_q.coarse_en && (PHASE_ERR_UI > limit_ext);

   // missing reference only counts as loss when software asks for it
   assign inact_out = fine_q.inactivity_loss_select && NO_ACTIVITY;

   // any single cause is enough; other detectors always take part
   assign lose_now = fine_out || coarse_out || inact_out || OTHER_LOSS;

   // limitation: the error inputs are taken as already settled levels; a
   // glitch on them for one cycle is enough to restart the whole dwell

   // ****************************************
   // lock qualification
   // ****************************************
   // last dwell count before lock; the window must hold this long unbroken
   assign dwell_last = 32'(LOCK_CNT - 1);
   assign dwell_done = (dwell_q >= dwell_last);

   // state: any cause drops straight to lost, so loss is never delayed
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_q <= plw_pkg::PLW_LOST;
      end else if (lose_now) begin
         state_q <= plw_pkg::PLW_LOST;
      end else begin
         case (state_q)
            plw_pkg::PLW_LOST: begin
               state_q <= plw_pkg::PLW_QUAL;
            end
            plw_pkg::PLW_QUAL: begin
               // dwell only matters when the fine window is in use
               if (!fine_q.fine_en || dwell_done) begin
                  state_q <= plw_pkg::PLW_LOCK;
               end
            end
            plw_pkg::PLW_LOCK: begin
               state_q <= plw_pkg::PLW_LOCK;
            end
            default: begin
               state_q <= plw_pkg::PLW_LOST;
            end
         endcase
      end
   end

   // a full second at the system clock needs 27 bits; the counter is kept at
   // 32 so a slower lock time can be chosen without touching the logic
   // dwell counter; saturates so a long qualification cannot wrap to zero
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         dwell_q <= 32'h0000_0000;
      end else if (lose_now || state_q != plw_pkg::PLW_QUAL) begin
         dwell_q <= 32'h0000_0000;
      end else if (!dwell_done) begin
         dwell_q <= dwell_q + 32'h0000_0001;
      end
   end

   // loss indication registered, one edge behind the state
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PHASE_LOST <= 1'b1;
      end else begin
         PHASE_LOST <= (state_q != plw_pkg::PLW_LOCK);
      end
   end

   // lock indication registered in step with the loss flag
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         PHASE_LOCKED <= 1'b0;
      end else begin
         PHASE_LOCKED <= (state_q == plw_pkg::PLW_LOCK);
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   // events are the changes of the registered indication, one cycle each
   assign lost_evt = PHASE_LOCKED && (state_q != plw_pkg::PLW_LOCK);
   // lock event is the mirror image of the loss event
   assign lock_evt = !PHASE_LOCKED && (state_q == plw_pkg::PLW_LOCK);
   assign evt_vec[plw_pkg::IRQ_LOST_BIT] = lost_evt;
   assign evt_vec[plw_pkg::IRQ_LOCK_BIT] = lock_evt;

   // write one to clear, only from a mapped write to the interrupt status word
   assign clr_vec = (wr_en && sel_irq_stat) ? PWDATA[1:0] : 2'h0;

   // set beats write-one-to-clear in the same cycle, so no event is lost
   for (genvar g = 0; g < $bits(evt_vec); g++) begin : g_irq
      always_ff @(posedge SYS_CLK or posedge RST) begin
         if (RST) begin
            irq_stat_q[g] <= 1'b0;
         end else if (evt_vec[g]) begin
            irq_stat_q[g] <= 1'b1;
         end else if (clr_vec[g]) begin
            irq_stat_q[g] <= 1'b0;
         end
      end
   end

   // level output, high while any enabled flag stands
   assign IRQ = |(irq_stat_q & irq_mask_q);
endmodule : plw_phase_loss

/* bench/plw_ref_model.sv */
`timescale 1ns/1ps
// reference side: detector readings lag the command by one cycle
module plw_ref_model (
   // commands
   input wire logic clk, input wire logic dead_cmd,
   input wire logic [15:0] deg_cmd, input wire logic [7:0] ui_cmd,
   // readings
   output logic [15:0] deg, output logic [7:0] ui, output logic dead
);
   initial {deg, ui, dead} = '0;
   // ********
   // readings follow after a cycle, like a real detector
   // ********
   always @(posedge clk) begin
      deg <= deg_cmd;
      ui <= ui_cmd;
      dead <= dead_cmd;
   end
endmodule : plw_ref_model

/* bench/plw_phase_loss_properties.sv */
`timescale 1ns/1ps
module plw_phase_loss_chk #(parameter int LOCK_CNT = 20) (
   // watched ports
   input wire logic SYS_CLK, input wire logic RST, input wire logic PSEL,
   input wire logic PENABLE, input wire logic PWRITE, input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA, input wire logic [15:0] PHASE_ERR_DEG,
   input wire logic [7:0] PHASE_ERR_UI, input wire logic NO_ACTIVITY,
   input wire logic OTHER_LOSS, input wire logic PHASE_LOST, input wire logic PHASE_LOCKED
);
   logic [7:0] fine_q, coarse_q;
   logic [31:0] quiet_q;
   logic fine_hit, coarse_hit, noact_hit, lose;
   // ********
   // shadow limits, so live causes are known
   // ********
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         fine_q <= plw_pkg::FINE_RST;
         coarse_q <= plw_pkg::COARSE_RST;
      end else if (PSEL && PENABLE && PWRITE) begin
         if (PADDR == 32'h0000_01CC) fine_q <= PWDATA[7:0];
         if (PADDR == 32'h0000_01D0) coarse_q <= PWDATA[7:0];
      end
   end
   // cycles since the last loss cause
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) quiet_q <= '0;
      else quiet_q <= lose ? '0 : quiet_q + 32'h0000_0001;
   end
   // window is code times 45 degrees, strictly greater trips
   assign fine_hit = fine_q[7] && PHASE_ERR_DEG > 16'(fine_q[2:0]) * 16'h002D;
   assign coarse_hit = coarse_q[7] && PHASE_ERR_UI > 8'(coarse_q[3:0]);
   assign noact_hit = fine_q[6] && NO_ACTIVITY;
   assign lose = fine_hit || coarse_hit || noact_hit || OTHER_LOSS;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence s_calm;
      !lose ##1 (PHASE_LOCKED && !lose);
   endsequence
   sequence s_free;
      (!lose && !fine_q[7])[*6];
   endsequence
   AST_FINE_LOSS: assert property (fine_hit |-> ##2 PHASE_LOST)
      else $error("fine window exit not seen as loss");
   AST_COARSE_LOSS: assert property (coarse_hit |-> ##2 PHASE_LOST)
      else $error("coarse limit exceeded without loss");
   AST_NOACT_LOSS: assert property (noact_hit |-> ##2 PHASE_LOST)
      else $error("inactivity not seen as loss");
   AST_OTHER_LOSS: assert property (OTHER_LOSS |-> ##2 PHASE_LOST)
      else $error("other detector loss ignored");
   AST_HOLD_LOCK: assert property (s_calm |=> PHASE_LOCKED)
      else $error("lock dropped without cause");
   AST_DWELL: assert property ($rose(PHASE_LOCKED) && fine_q[7] |-> quiet_q >= LOCK_CNT)
      else $error("lock declared before dwell time");
   AST_FINE_OFF: assert property (s_free |-> PHASE_LOCKED)
      else $error("no fast lock with fine check off");
   AST_INVERSE: assert property (PHASE_LOCKED != PHASE_LOST)
      else $error("lock and loss flags agree");
endmodule : plw_phase_loss_chk
bind plw_phase_loss plw_phase_loss_chk #(.LOCK_CNT(LOCK_CNT)) chk_u (.SYS_CLK(SYS_CLK),
   .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PHASE_ERR_DEG(PHASE_ERR_DEG), .PHASE_ERR_UI(PHASE_ERR_UI),
   .NO_ACTIVITY(NO_ACTIVITY), .OTHER_LOSS(OTHER_LOSS), .PHASE_LOST(PHASE_LOST),
   .PHASE_LOCKED(PHASE_LOCKED));

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
   localparam int LC = 20;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, dead_c = 1'b0;
   logic other = 1'b0, pready, pslverr, dead, lost, locked, irq, er;
   logic [31:0] padr = '0, pwd = '0, prd, rd;
   logic [15:0] deg_c = '0, deg;
   logic [7:0] ui_c = '0, ui;
   int err_total = 0, n_tests = 0, cyc = 0;
   always #5 clk = ~clk;
   plw_ref_model ref_u (.clk(clk), .dead_cmd(dead_c), .deg_cmd(deg_c), .ui_cmd(ui_c),
      .deg(deg), .ui(ui), .dead(dead));
   plw_phase_loss #(.LOCK_CNT(LC)) dut_u (.SYS_CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(pready), .PSLVERR(pslverr), .PHASE_ERR_DEG(deg), .PHASE_ERR_UI(ui),
      .NO_ACTIVITY(dead), .OTHER_LOSS(other), .PHASE_LOST(lost), .PHASE_LOCKED(locked),
      .IRQ(irq));
   // ********
   // shared helpers
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // idle edge first, so back-to-back calls never double-drive psel
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= {22'h00_0000, idx, 2'h0};
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prd;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // flags read mid-cycle; returns on a rising edge so stimulus follows it there
   task automatic st(input int n, input logic [1:0] exp);
      repeat (n) @(posedge clk);
      @(negedge clk);
      chk({30'h0000_0000, lost, locked}, {30'h0000_0000, exp});
      @(posedge clk);
   endtask : st
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   // ********
   // scenarios
   // ********
   task automatic t_fine;
      apb(1'b0, plw_pkg::FINE_IDX, '0);
      chk(rd, 32'h0000_00A2);
      st(0, 2'b10);
      st(LC, 2'b01);
      deg_c <= 16'h005A;
      st(4, 2'b01);
      deg_c <= 16'h005B;
      st(4, 2'b10);
      deg_c <= 16'h0000;
      st(10, 2'b10);
   endtask : t_fine
   task automatic t_coarse;
      apb(1'b0, plw_pkg::COARSE_IDX, '0);
      chk(rd, 32'h0000_0085);
      ui_c <= 8'h05;
      st(LC, 2'b01);
      ui_c <= 8'h06;
      st(4, 2'b10);
      apb(1'b1, plw_pkg::COARSE_IDX, 32'h0000_0005);
      ui_c <= 8'h0F;
      st(LC + 6, 2'b01);
   endtask : t_coarse
   task automatic t_other;
      apb(1'b1, plw_pkg::FINE_IDX, 32'h0000_0022);
      deg_c <= 16'h012C;
      dead_c <= 1'b1;
      st(6, 2'b01);
      apb(1'b1, plw_pkg::FINE_IDX, 32'h0000_0062);
      st(2, 2'b10);
      dead_c <= 1'b0;
      st(8, 2'b01);
      other <= 1'b1;
      st(4, 2'b10);
      other <= 1'b0;
      st(8, 2'b01);
   endtask : t_other
   task automatic t_irq;
      apb(1'b0, plw_pkg::IRQ_STAT_IDX, '0);
      chk(rd, 32'h0000_0003);
      apb(1'b1, plw_pkg::IRQ_MASK_IDX, 32'h0000_0003);
      @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      apb(1'b1, plw_pkg::IRQ_STAT_IDX, 32'h0000_0003);
      apb(1'b0, plw_pkg::IRQ_STAT_IDX, '0);
      chk({rd[31:1], irq}, 32'h0000_0000);
      apb(1'b0, 8'h10, '0);
      chk({rd[31:1], er}, 32'h0000_0001);
   endtask : t_irq
   // cycle ceiling, some eighteen times the expected run of about 165 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_fine();
      t_coarse();
      t_other();
      t_irq();
      finish_test();
   end
endmodule : tb
